// File: hw/asr_receiver.sv
/*
 Receive side of the asynchronous serial port: bit sampler, two-entry
 character buffer with framing and ninth-bit status, overrun and address
 detection, and an APB register slave.
 Assumes serial_in is already synchronous to clk and idles high.
*/
`timescale 1ns/1ps
module asr_receiver #(
   parameter int DEPTH = asr_pkg::BUF_DEPTH  // Buffer depth
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Serial line
   input  wire logic        serial_in,
   // Status out
   output logic             receive_interrupt_flag
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ASR_IDLE, ASR_START, ASR_DATA, ASR_STOP} asr_state_t;

   asr_state_t  state_reg;          // Receiver sequencer
   logic [15:0] baud_reg;           // Cycles per bit
   logic [15:0] cnt_reg;            // Bit time counter
   logic [3:0]  bit_idx_reg;        // Data bit index
   logic [8:0]  receive_shift_register; // Incoming bits
   logic        serial_port_enable_reg, continuous_receive_enable_reg, rx9_reg, address_detect_enable_reg;
   logic        overrun_reg;        // Sticky overrun
   logic [9:0]  buf_mem [DEPTH];    // {framing, ninth, data}
   logic        rd_ptr_reg, wr_ptr_reg;
   logic [1:0]  count_reg;          // Characters held
   logic        done;               // Character complete this cycle
   logic        stop_ok;            // Stop bit sampled high
   logic        keep;               // Character passes address filter
   logic        push, pop;
   logic        wr_acc, rd_acc;
   logic [9:0]  head;               // Oldest unread entry
   logic [7:0]  ctrl_view;

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign head   = buf_mem[rd_ptr_reg];
   // Nothing enters the buffer while overrun stands
   assign done    = (state_reg == ASR_STOP) && (cnt_reg == 16'h0000);
   assign stop_ok = serial_in;
   // Address mode needs nine-bit reception and a set ninth bit
   assign keep = !(address_detect_enable_reg && rx9_reg) || receive_shift_register[8]; // [R17] [R18]
   // A pop in the same cycle frees the slot, so a full buffer still takes the character
   assign push = done && keep && !overrun_reg && ((count_reg < 2'(DEPTH)) || pop); // [R5] [R11]
   // Pop on data read, only when something is held
   assign pop  = rd_acc && (paddr == asr_pkg::DATA_OFF) && (count_reg != 2'h0); // [R4]

   ////////////////////////////////////////////////////////////////////////
   // Control bits; a control write loads all four, port enable clear leaves the others as written
   always_ff @(posedge clk) begin
      if (srst) begin
         serial_port_enable_reg  <= 1'b0;
         continuous_receive_enable_reg  <= 1'b0;
         rx9_reg   <= 1'b0;
         address_detect_enable_reg <= 1'b0;
         baud_reg  <= asr_pkg::BAUD_RST;
      end else if (wr_acc && paddr == asr_pkg::STAT_CTRL_OFF) begin
         serial_port_enable_reg  <= pwdata[asr_pkg::SERIAL_PORT_ENABLE_BIT];
         continuous_receive_enable_reg  <= pwdata[asr_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT];
         rx9_reg   <= pwdata[asr_pkg::RX9_BIT];
         address_detect_enable_reg <= pwdata[asr_pkg::ADDR_BIT]; // [R17] [R19]
      end else if (wr_acc && paddr == asr_pkg::BAUD_OFF) begin
         baud_reg  <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit sampler; runs only while port and receive are enabled
   always_ff @(posedge clk) begin
      if (srst || !serial_port_enable_reg || !continuous_receive_enable_reg) begin
         state_reg   <= ASR_IDLE;
         cnt_reg     <= 16'h0000;
         bit_idx_reg <= 4'h0;
         receive_shift_register <= 9'h000;
      end else begin
         case (state_reg)
            ASR_IDLE: begin
               // Falling edge: wait half a bit to mid-start
               if (!serial_in) begin
                  state_reg <= ASR_START;
                  cnt_reg   <= baud_reg >> 1;
               end
            end
            ASR_START: begin
               if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else if (serial_in) begin
                  state_reg <= ASR_IDLE;  // Glitch, not a start bit
               end else begin
                  state_reg   <= ASR_DATA;
                  cnt_reg     <= baud_reg - 16'h0001;
                  bit_idx_reg <= 4'h0;
               end
            end
            ASR_DATA: begin
               if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else begin
                  // LSB first; shift into the top, nine bits in nine-bit mode
                  if (rx9_reg) begin
                     receive_shift_register <= {serial_in, receive_shift_register[8:1]}; // [R13]
                  end else begin
                     receive_shift_register <= {1'b0, serial_in, receive_shift_register[7:1]};
                  end
                  cnt_reg <= baud_reg - 16'h0001;
                  if (bit_idx_reg == (rx9_reg ? 4'h8 : 4'h7)) begin
                     state_reg <= ASR_STOP;
                  end else begin
                     bit_idx_reg <= bit_idx_reg + 4'h1;
                  end
               end
            end
            ASR_STOP: begin
               if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else begin
                  state_reg <= ASR_IDLE;  // Receive continues after errors
               end
            end
            default: state_reg <= ASR_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Buffer storage; framing status travels with each character
   always_ff @(posedge clk) begin
      if (push) begin
         buf_mem[wr_ptr_reg] <= {!stop_ok, receive_shift_register}; // [R1] [R2]
      end
   end

   // Pointers and count; port enable clear empties the buffer
   always_ff @(posedge clk) begin
      if (srst || !serial_port_enable_reg) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;  // [R6]
      end else begin
         if (push) begin
            wr_ptr_reg <= !wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= !rd_ptr_reg;
         end
         count_reg <= count_reg + 2'(push) - 2'(pop); // [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overrun: third full character while full; only enables clear it
   always_ff @(posedge clk) begin
      if (srst || !serial_port_enable_reg || !continuous_receive_enable_reg) begin
         overrun_reg <= 1'b0;  // [R12]
      end else if (done && keep && count_reg == 2'(DEPTH) && !pop) begin
         overrun_reg <= 1'b1;  // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status view: control bits, overrun and the head entry; empty buffer shows zero framing and ninth bits
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[asr_pkg::SERIAL_PORT_ENABLE_BIT]    = serial_port_enable_reg;
      ctrl_view[asr_pkg::RX9_BIT]     = rx9_reg;
      ctrl_view[asr_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT]    = continuous_receive_enable_reg;
      ctrl_view[asr_pkg::ADDR_BIT]    = address_detect_enable_reg;
      ctrl_view[asr_pkg::OVERRUN_BIT] = overrun_reg;
      // Framing follows the oldest entry; receive enable has no say here
      ctrl_view[asr_pkg::FRAME_BIT] = (count_reg != 2'h0) && head[9]; // [R3] [R7]
      ctrl_view[asr_pkg::NINTH_BIT] = (count_reg != 2'h0) && head[8]; // [R14]
   end

   // APB read data and answer; zero wait states
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               asr_pkg::STAT_CTRL_OFF: prdata <= {24'h000000, ctrl_view};
               asr_pkg::DATA_OFF:      prdata <= {24'h000000, head[7:0]};
               asr_pkg::BAUD_OFF:      prdata <= {16'h0000, baud_reg};
               asr_pkg::FLAGS_OFF:
                  prdata <= 32'(count_reg != 2'h0) << asr_pkg::RXFLAG_BIT;
               default: pslverr <= !pwrite;  // Unmapped reads error
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive flag: buffer nonempty; framing alone raises nothing
   always_ff @(posedge clk) begin
      if (srst || !serial_port_enable_reg) begin
         receive_interrupt_flag <= 1'b0;
      end else if (wr_acc && paddr == asr_pkg::STAT_CTRL_OFF && !pwdata[asr_pkg::SERIAL_PORT_ENABLE_BIT]) begin
         // Port disable drops the flag at the write, not a cycle later
         receive_interrupt_flag <= 1'b0;  // [R6]
      end else begin
         receive_interrupt_flag <= (count_reg + 2'(push) - 2'(pop)) != 2'h0; // [R20] [R8]
      end
   end
endmodule

// File: hw/asr_pkg.sv
/*
 Constants for the receive half of the asynchronous serial port: register
 offsets, bit positions, reset values and the receiver timing.
 Assumes an APB slave with 32-bit data and a 10 MHz system clock.
*/
// Operation
// [R1] Framing status stored with each character
// [R2] Missing stop bit flags framing error
// [R3] Flag shows oldest unread character status
// [R4] Flag read-only; data read pops buffer
// [R5] Framing error never stops further reception
// [R6] Port enable clear resets, clears flag
// [R7] Receive enable clear keeps framing flag
// [R8] No interrupt from framing error alone
// [R9] Buffer holds at most two characters
// [R10] Third character while full sets overrun
// [R11] Overrun keeps data readable, blocks reception
// [R12] Overrun cleared only by enable clears
// [R13] Nine-bit mode shifts nine data bits
// [R14] Ninth-bit field shows oldest character's bit
// [R15] Software reads ninth bit before data
// [R16] Software reads framing flag before data
// [R17] Address detect enable selects address mode
// [R18] Address mode keeps only ninth-bit-set characters
// [R19] Software toggles address detect around messages
// [R20] Receive flag high while buffer nonempty
package asr_pkg;
   // Register byte offsets
   localparam logic [11:0] STAT_CTRL_OFF = 12'h000;  // receive_status_control
   localparam logic [11:0] DATA_OFF      = 12'h004;  // receive_data_register
   localparam logic [11:0] BAUD_OFF      = 12'h008;  // Bit period divider
   localparam logic [11:0] FLAGS_OFF     = 12'h00c;  // peripheral_interrupt_flags
   // Control/status bit positions
   localparam int NINTH_BIT  = 0;  // received_ninth_bit (RO)
   localparam int OVERRUN_BIT = 1; // overrun_error_flag (RO)
   localparam int FRAME_BIT  = 2;  // framing_error_flag (RO)
   localparam int ADDR_BIT   = 3;  // address_detect_enable
   localparam int CONTINUOUS_RECEIVE_ENABLE_BIT   = 4;  // continuous_receive_enable
   localparam int RX9_BIT    = 6;  // nine_bit_receive_enable
   localparam int SERIAL_PORT_ENABLE_BIT   = 7;  // serial_port_enable
   localparam int RXFLAG_BIT = 5;  // receive_interrupt_flag in flags word
   // Reset values
   localparam logic [15:0] BAUD_RST = 16'h0040;  // Cycles per bit
   localparam int          BUF_DEPTH = 2;        // Characters held
   // Bit timing: nominal rate and derived cycles per bit
   localparam int CLK_HZ    = 10_000_000;
   localparam int BAUD_HZ   = 156_250;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
endpackage

// File: dv/asr_props.sv
/* Checker for the receive port: APB handshake and receive flag timing.
   Assumes it is bound to asr_receiver and sees only its ports. */
`timescale 1ns/1ps
module asr_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Line and flag
   input wire logic        serial_in,
   input wire logic        receive_interrupt_flag
);
   ////////////////////////////////////////
   wire logic setup  = psel && !penable;  // Setup cycle
   wire logic mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c};  // Mapped words
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_ready_after_setup: assert property (setup |=> pready) else $error("ready missing");
   a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready too long");
   a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
   a_setup_not_ready: assert property (setup |-> !pready) else $error("ready in setup");
   a_err_unmapped: assert property (setup && !pwrite && !mapped |=> pslverr) else $error("no err");
   a_no_err_ok: assert property (setup && (pwrite || mapped) |=> !pslverr) else $error("bad err");
   a_flag_falls_read: assert property ($fell(receive_interrupt_flag) |->
      $past(psel && penable) || $past(psel && penable, 2)) else $error("flag fell alone");
   a_flag_min_high: assert property ($rose(receive_interrupt_flag) |=> receive_interrupt_flag)
      else $error("flag glitch");
endmodule
bind asr_receiver asr_props P (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .serial_in(serial_in), .receive_interrupt_flag(receive_interrupt_flag));

// File: dv/asr_line_model.sv
/* Remote serial transmitter: start bit, LSB first data, one stop bit.
   Assumes the receiver divider matches BIT cycles per bit. */
`timescale 1ns/1ps
module asr_line_model #(
   parameter int BIT = 64  // Cycles per bit
) (
   input wire logic clk,   // System clock
   output logic     line   // Serial line, idles high
);
   ////////////////////////////////////////
   initial line = 1'b1;  // Idle level
   // One character; stop_ok low leaves the stop bit missing
   task automatic send(input logic [8:0] d, input int nb, input logic stop_ok);
      int i;
      line <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (i = 0; i < nb; i++) begin
         line <= d[i];
         repeat (BIT) @(posedge clk);
      end
      line <= stop_ok;
      repeat (BIT) @(posedge clk);
      line <= 1'b1;  // Idle gap so the next start edge is seen
      repeat (BIT) @(posedge clk);
   endtask
endmodule

// File: dv/tb_top.sv
/* Self-checking bench for the receive port over APB.
   Assumes the divider resets to 64 cycles per bit. */
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, serial_in, err, rif;
   int          bad_count = 0, checks = 0, cycles = 0;
   always #50 clk = ~clk;  // 10 MHz
   asr_receiver DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .serial_in(serial_in), .receive_interrupt_flag(rif));
   asr_line_model #(.BIT(asr_pkg::BIT_CYCLES)) TX (.clk(clk), .line(serial_in));
   ////////////////////////////////////////
   task automatic results;
      $display("mismatches %0d comparisons %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] c); apb(1'b1, 12'h000, {24'h0, c}); endtask
   task automatic st(input logic [2:0] e); apb(1'b0, 12'h000, 32'h0); chk(rd[2:0], e); endtask
   task automatic dat(input logic [7:0] e); apb(1'b0, 12'h004, 32'h0); chk(rd[7:0], e); endtask
   ////////////////////////////////////////
   task automatic t_regs;
      apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0); chk(rd, {16'h0000, asr_pkg::BAUD_RST});
      apb(1'b0, 12'h010, 32'h0); chk({31'h0, err}, 32'h1);
   endtask
   task automatic t_frame;
      wr(8'h90); TX.send(9'h055, 8, 1'b1); TX.send(9'h0a3, 8, 1'b0);
      st(3'h0); dat(8'h55);
      st(3'h4);
      TX.send(9'h03c, 8, 1'b1);
      dat(8'ha3); st(3'h0); chk({31'h0, rif}, 32'h1);
      dat(8'h3c); chk({31'h0, rif}, 32'h0);
      TX.send(9'h011, 8, 1'b0); wr(8'h80); st(3'h4);
      wr(8'h00); st(3'h0); chk({31'h0, rif}, 32'h0);
   endtask
   task automatic t_over;
      wr(8'h90); TX.send(9'h001, 8, 1'b1); TX.send(9'h002, 8, 1'b1); TX.send(9'h003, 8, 1'b1);
      st(3'h2); TX.send(9'h004, 8, 1'b1);
      dat(8'h01); dat(8'h02); chk({31'h0, rif}, 32'h0);
      st(3'h2); wr(8'h80); st(3'h0);
      wr(8'h90); TX.send(9'h005, 8, 1'b1); dat(8'h05);
   endtask
   task automatic t_nine;
      wr(8'hd0); TX.send(9'h1a5, 9, 1'b1); st(3'h1); dat(8'ha5);
      wr(8'hd8); TX.send(9'h033, 9, 1'b1); chk({31'h0, rif}, 32'h0);
      TX.send(9'h155, 9, 1'b1); st(3'h1); dat(8'h55);
      wr(8'hd0); TX.send(9'h022, 9, 1'b1); st(3'h0); dat(8'h22);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs(); t_frame(); t_over(); t_nine();
      results();
   end
endmodule
